// *** common/gauge_pkg.sv ***
// Constants shared by the gauge two-wire slave and the bus master end.
// Assumes a single 250 MHz system clock on both ends.
// Function
// - Slave only, one configurable 7-bit address
// - SDA input on receive, open-drain on send
// - Only the master starts a transaction
// - SDA stable while SCL high, bit per clock
// - START is SDA fall, STOP SDA rise, SCL high
// - Repeated START begins a new transfer
// - STOP mid-byte discards the partial byte
// - Only fully acknowledged bytes are committed
// - Eight bits MSB first, then acknowledge slot
// - Slave may hold SCL low until ready
// - Idle bus has both lines high
// - Acknowledge is SDA low around ninth clock
// - No-acknowledge is SDA high around ninth clock
// - START then STOP is ignored, never issued
// - Direction bit one reads, zero writes
// - Both lines low 2 s forces discharge off
// - Any override cause holds discharge off
// - Override only turns the switch off
// - No bus activity during protection fault
// - Framing follows SMBus conventions
package gauge_pkg;
  // ==========================================================
  // Timing
  localparam int          SYS_CLK_KHZ     = 250000;
  localparam int          REMOVE_TIME_MS  = 2000;
  localparam longint      REMOVE_CYC_PROD = longint'(REMOVE_TIME_MS) * longint'(SYS_CLK_KHZ);
  localparam int unsigned REMOVE_CYCLES   = 32'(REMOVE_CYC_PROD);
  localparam int          REMOVE_CNT_W    = 29;
  localparam int          SCL_KHZ         = 250;
  localparam logic [11:0] SCL_HALF        = 12'(SYS_CLK_KHZ / (2 * SCL_KHZ));
  localparam logic [11:0] SCL_HALF_LAST   = SCL_HALF - 12'h001;
  localparam logic [11:0] SCL_QUARTER     = SCL_HALF >> 1;
  // ==========================================================
  // Framing
  localparam int          ADDR_W          = 7;
  localparam int          BYTE_W          = 8;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  ACK_SLOT        = 4'h8;
  localparam logic [8:0]  READ_FRAME      = 9'h1FF;
  localparam logic        DIR_READ        = 1'b1;
  localparam logic        ACK_RELEASED    = 1'b1;
endpackage

// *** common/two_wire_if.sv ***
// Two-wire bus carrier joining the gauge slave and the master end.
// Resolves the open-drain wires with an implied pull-up on each line.
`timescale 1ns/1ps
interface two_wire_if;
  // Slave end drivers
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // Master end drivers
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  // Resolved wire levels
  logic scl;
  logic sda;

  // ==========================================================
  // Wired-AND with pull-up, idle high
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));

  modport device (input scl, input sda,
                  output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport host   (input scl, input sda,
                  output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface // two_wire_if

// *** rtl/sync_2ff.sv ***
// Two flip-flop level synchronizer, parameterised width.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Data
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // ==========================================================
  // First stage feeds only the second; lines reset high as idle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync_2ff

// *** rtl/gauge_two_wire_slave.sv ***
// Gauge-side two-wire slave with pack-removal discharge override.
// Assumes the master honours SCL stretching and the user side runs on sys_clk.
`timescale 1ns/1ps
module gauge_two_wire_slave #(
  parameter int unsigned REMOVE_CYCLES = gauge_pkg::REMOVE_CYCLES
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  // Bus
  two_wire_if.device                       bus,
  // Address
  input  wire logic [gauge_pkg::ADDR_W-1:0] own_addr,
  // Received bytes
  output      logic [gauge_pkg::BYTE_W-1:0] rx_data,
  output      logic                        rx_valid,
  input  wire logic                        rx_ready,
  // Bytes to return
  input  wire logic [gauge_pkg::BYTE_W-1:0] tx_data,
  input  wire logic                        tx_valid,
  output      logic                        tx_ready,
  // Frame status
  output      logic                        frame_end,
  // Protection and discharge
  input  wire logic                        chg_fault,
  input  wire logic                        dsg_fault,
  input  wire logic                        hw_dsg_on,
  input  wire logic                        pack_cutoff_cmd,
  input  wire logic                        uv_override,
  output      logic                        discharge_switch,
  output      logic                        pack_removed
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK} slv_e;

  slv_e                              state_r, state_nxt;
  logic [3:0]                        cnt_r, cnt_nxt;
  logic [gauge_pkg::BYTE_W-1:0]      sh_r, sh_nxt;
  logic                              dir_r, dir_nxt;
  logic                              ack_r, ack_nxt;
  logic                              sda_oe_r, sda_oe_nxt;
  logic                              scl_oe_r, scl_oe_nxt;
  logic [gauge_pkg::BYTE_W-1:0]      rx_data_r, rx_data_nxt;
  logic                              rx_valid_r, rx_valid_nxt;
  logic                              tx_ready_r, tx_ready_nxt;
  logic                              frame_end_r, frame_end_nxt;
  logic                              removed_r, removed_nxt;
  logic                              dsg_r, dsg_nxt;
  logic [gauge_pkg::REMOVE_CNT_W-1:0] rm_cnt_r, rm_cnt_nxt;
  logic                              do_load;
  logic [1:0]                        line_s;
  logic                              scl_s, sda_s, scl_d_r, sda_d_r;

  // ==========================================================
  // Line synchronizers and edge history
  sync_2ff #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       ({bus.scl, bus.sda}),
    .q       (line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // Decoded bus events from synchronized samples only
  wire scl_rise  = scl_s && !scl_d_r;
  wire scl_fall  = !scl_s && scl_d_r;
  wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire bus_fault = chg_fault || dsg_fault;
  wire addr_hit  = (sh_r[gauge_pkg::BYTE_W-1:1] == own_addr);
  wire byte_done = (cnt_r == gauge_pkg::BITS_PER_BYTE);
  wire both_low  = !scl_s && !sda_s;
  wire both_high = scl_s && sda_s;
  wire rm_hit    = (rm_cnt_r == gauge_pkg::REMOVE_CNT_W'(REMOVE_CYCLES - 1));
  wire any_cause = pack_cutoff_cmd || uv_override || removed_r;

  // ==========================================================
  // Protocol sequencer
  always_comb
  begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    sh_nxt        = sh_r;
    dir_nxt       = dir_r;
    ack_nxt       = ack_r;
    sda_oe_nxt    = sda_oe_r;
    scl_oe_nxt    = scl_oe_r;
    rx_data_nxt   = rx_data_r;
    rx_valid_nxt  = rx_valid_r && !rx_ready;
    tx_ready_nxt  = 1'b0;
    frame_end_nxt = 1'b0;
    do_load       = 1'b0;
    if (bus_fault)
    begin
      // Stay off the bus entirely while protection holds a switch off
      state_nxt  = ST_IDLE;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      // Partial byte in sh_r is simply dropped
      state_nxt     = ST_IDLE;
      sda_oe_nxt    = 1'b0;
      scl_oe_nxt    = 1'b0;
      frame_end_nxt = (state_r != ST_ADDR) || (cnt_r != 4'h0);
    end
    else if (start_det)
    begin
      state_nxt  = ST_ADDR;
      cnt_nxt    = 4'h0;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[gauge_pkg::BYTE_W-2:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            if (addr_hit)
            begin
              sda_oe_nxt = 1'b1;
              dir_nxt    = sh_r[0];
              state_nxt  = ST_AACK;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            sda_oe_nxt = 1'b0;
            cnt_nxt    = 4'h0;
            state_nxt  = (dir_r == gauge_pkg::DIR_READ) ? ST_TX : ST_RX;
            do_load    = (dir_r == gauge_pkg::DIR_READ);
          end
        end
        ST_RX:
        begin
          if (scl_oe_r)
          begin
            // Stretched until the previous byte is taken
            if (!rx_valid_r)
            begin
              scl_oe_nxt = 1'b0;
              sda_oe_nxt = 1'b1;
              state_nxt  = ST_RACK;
            end
          end
          else if (scl_rise)
          begin
            sh_nxt  = {sh_r[gauge_pkg::BYTE_W-2:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            if (rx_valid_r)
              scl_oe_nxt = 1'b1;
            else
            begin
              sda_oe_nxt = 1'b1;
              state_nxt  = ST_RACK;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_fall)
          begin
            // Byte is committed only once its acknowledge slot closes
            sda_oe_nxt   = 1'b0;
            rx_data_nxt  = sh_r;
            rx_valid_nxt = 1'b1;
            cnt_nxt      = 4'h0;
            state_nxt    = ST_RX;
          end
        end
        ST_TX:
        begin
          if (scl_oe_r)
            do_load = 1'b1;
          else if (scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              sda_oe_nxt = 1'b0;
              state_nxt  = ST_TACK;
            end
            else
            begin
              sh_nxt     = {sh_r[gauge_pkg::BYTE_W-2:0], 1'b0};
              sda_oe_nxt = !sh_r[gauge_pkg::BYTE_W-2];
            end
          end
        end
        ST_TACK:
        begin
          if (scl_rise)
            ack_nxt = (sda_s != gauge_pkg::ACK_RELEASED);
          else if (scl_fall)
          begin
            cnt_nxt   = 4'h0;
            state_nxt = ack_r ? ST_TX : ST_IDLE;
            do_load   = ack_r;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
      // Next byte to return; stretch SCL while none is offered
      if (do_load)
      begin
        if (tx_valid)
        begin
          sh_nxt       = tx_data;
          sda_oe_nxt   = !tx_data[gauge_pkg::BYTE_W-1];
          tx_ready_nxt = 1'b1;
          scl_oe_nxt   = 1'b0;
        end
        else
          scl_oe_nxt = 1'b1;
      end
    end
  end

  // ==========================================================
  // Pack-removal watch and discharge override
  assign rm_cnt_nxt  = !both_low ? '0 : (rm_hit ? rm_cnt_r : rm_cnt_r + 1'b1);
  assign removed_nxt = (both_low && rm_hit) || (removed_r && !both_high);
  assign dsg_nxt     = hw_dsg_on && !any_cause;

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_r     <= ST_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= '0;
      dir_r       <= 1'b0;
      ack_r       <= 1'b0;
      sda_oe_r    <= 1'b0;
      scl_oe_r    <= 1'b0;
      rx_data_r   <= '0;
      rx_valid_r  <= 1'b0;
      tx_ready_r  <= 1'b0;
      frame_end_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      dir_r       <= dir_nxt;
      ack_r       <= ack_nxt;
      sda_oe_r    <= sda_oe_nxt;
      scl_oe_r    <= scl_oe_nxt;
      rx_data_r   <= rx_data_nxt;
      rx_valid_r  <= rx_valid_nxt;
      tx_ready_r  <= tx_ready_nxt;
      frame_end_r <= frame_end_nxt;
    end
  end

  // Edge history and override registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      rm_cnt_r  <= '0;
      removed_r <= 1'b0;
      dsg_r     <= 1'b0;
    end
    else
    begin
      scl_d_r   <= scl_s;
      sda_d_r   <= sda_s;
      rm_cnt_r  <= rm_cnt_nxt;
      removed_r <= removed_nxt;
      dsg_r     <= dsg_nxt;
    end
  end

  // ==========================================================
  // Outputs; pins only ever pull low
  assign bus.dev_scl_o     = 1'b0;
  assign bus.dev_sda_o     = 1'b0;
  assign bus.dev_scl_oe    = scl_oe_r;
  assign bus.dev_sda_oe    = sda_oe_r;
  assign rx_data           = rx_data_r;
  assign rx_valid          = rx_valid_r;
  assign tx_ready          = tx_ready_r;
  assign frame_end         = frame_end_r;
  assign discharge_switch  = dsg_r;
  assign pack_removed      = removed_r;
endmodule // gauge_two_wire_slave

// *** rtl/two_wire_master.sv ***
// Host-side master: one START, address byte, one data byte if the address is acknowledged, STOP.
// Assumes the slave may stretch SCL; SCL is derived from sys_clk.
`timescale 1ns/1ps
module two_wire_master (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  // Bus
  two_wire_if.host                          bus,
  // Command
  input  wire logic                         cmd_valid,
  input  wire logic                         cmd_read,
  input  wire logic [gauge_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [gauge_pkg::BYTE_W-1:0] cmd_wdata,
  output      logic                         cmd_ready,
  // Result
  output      logic                         done,
  output      logic                         ack_ok,
  output      logic [gauge_pkg::BYTE_W-1:0] rd_data
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_A, M_STOP_B, M_FREE} mst_e;

  mst_e                         st_r, st_nxt;
  logic [11:0]                  tmr_r, tmr_nxt;
  logic [3:0]                   bit_r, bit_nxt;
  logic                         byte_r, byte_nxt;
  logic [8:0]                   frame_r, frame_nxt;
  logic [8:0]                   in_r, in_nxt;
  logic                         rd_r, rd_nxt;
  logic [gauge_pkg::BYTE_W-1:0] wd_r, wd_nxt;
  logic                         scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic                         rdy_r, rdy_nxt, done_r, done_nxt, ok_r, ok_nxt;
  logic [gauge_pkg::BYTE_W-1:0] rdd_r, rdd_nxt;
  logic [1:0]                   line_s;

  // ==========================================================
  // Line synchronizers
  sync_2ff #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       ({bus.scl, bus.sda}),
    .q       (line_s)
  );

  wire scl_s    = line_s[1];
  wire sda_s    = line_s[0];
  wire half_end = (tmr_r == gauge_pkg::SCL_HALF_LAST);
  wire quarter  = (tmr_r == gauge_pkg::SCL_QUARTER);
  wire ack_seen = !sda_s;

  // ==========================================================
  // Bit engine; data bits move SDA only halfway into the low phase
  always_comb
  begin
    st_nxt     = st_r;
    tmr_nxt    = tmr_r + 12'h001;
    bit_nxt    = bit_r;
    byte_nxt   = byte_r;
    frame_nxt  = frame_r;
    in_nxt     = in_r;
    rd_nxt     = rd_r;
    wd_nxt     = wd_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rdy_nxt    = rdy_r;
    done_nxt   = 1'b0;
    ok_nxt     = ok_r;
    rdd_nxt    = rdd_r;
    unique case (st_r)
      M_IDLE:
      begin
        tmr_nxt = 12'h000;
        if (cmd_valid && rdy_r)
        begin
          // Only this end ever opens a transaction
          frame_nxt  = {cmd_addr, cmd_read, gauge_pkg::ACK_RELEASED};
          rd_nxt     = cmd_read;
          wd_nxt     = cmd_wdata;
          rdy_nxt    = 1'b0;
          sda_oe_nxt = 1'b1;
          bit_nxt    = 4'h0;
          byte_nxt   = 1'b0;
          st_nxt     = M_START;
        end
      end
      M_START:
      begin
        if (half_end)
        begin
          scl_oe_nxt = 1'b1;
          tmr_nxt    = 12'h000;
          st_nxt     = M_LOW;
        end
      end
      M_LOW:
      begin
        if (quarter)
          sda_oe_nxt = !frame_r[8];
        if (half_end)
        begin
          scl_oe_nxt = 1'b0;
          tmr_nxt    = 12'h000;
          st_nxt     = M_HIGH;
        end
      end
      M_HIGH:
      begin
        // High phase is timed only once SCL is really high
        if (!scl_s)
          tmr_nxt = 12'h000;
        else if (half_end)
        begin
          scl_oe_nxt = 1'b1;
          tmr_nxt    = 12'h000;
          in_nxt     = {in_r[7:0], sda_s};
          if (bit_r == gauge_pkg::ACK_SLOT)
          begin
            bit_nxt = 4'h0;
            if (!byte_r && ack_seen)
            begin
              byte_nxt  = 1'b1;
              frame_nxt = rd_r ? gauge_pkg::READ_FRAME : {wd_r, gauge_pkg::ACK_RELEASED};
              st_nxt    = M_LOW;
            end
            else
            begin
              ok_nxt  = byte_r && (rd_r || ack_seen);
              rdd_nxt = in_r[7:0];
              st_nxt  = M_STOP_A;
            end
          end
          else
          begin
            bit_nxt   = bit_r + 4'h1;
            frame_nxt = {frame_r[7:0], 1'b0};
            st_nxt    = M_LOW;
          end
        end
      end
      M_STOP_A:
      begin
        if (quarter)
          sda_oe_nxt = 1'b1;
        if (half_end)
        begin
          scl_oe_nxt = 1'b0;
          tmr_nxt    = 12'h000;
          st_nxt     = M_STOP_B;
        end
      end
      M_STOP_B:
      begin
        if (!scl_s)
          tmr_nxt = 12'h000;
        else if (half_end)
        begin
          sda_oe_nxt = 1'b0;
          tmr_nxt    = 12'h000;
          st_nxt     = M_FREE;
        end
      end
      M_FREE:
      begin
        // Bus left idle for a half period before the next command
        if (half_end)
        begin
          rdy_nxt  = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = M_IDLE;
        end
      end
      default: st_nxt = M_IDLE;
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_r     <= M_IDLE;
      tmr_r    <= 12'h000;
      bit_r    <= 4'h0;
      byte_r   <= 1'b0;
      frame_r  <= '0;
      in_r     <= '0;
      rd_r     <= 1'b0;
      wd_r     <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rdy_r    <= 1'b1;
      done_r   <= 1'b0;
      ok_r     <= 1'b0;
      rdd_r    <= '0;
    end
    else
    begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      bit_r    <= bit_nxt;
      byte_r   <= byte_nxt;
      frame_r  <= frame_nxt;
      in_r     <= in_nxt;
      rd_r     <= rd_nxt;
      wd_r     <= wd_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      rdy_r    <= rdy_nxt;
      done_r   <= done_nxt;
      ok_r     <= ok_nxt;
      rdd_r    <= rdd_nxt;
    end
  end

  // Outputs
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;
  assign cmd_ready       = rdy_r;
  assign done            = done_r;
  assign ack_ok          = ok_r;
  assign rd_data         = rdd_r;
endmodule // two_wire_master

// *** dv/two_wire_chk.sv ***
// Checker on the shared two-wire lines and the slave's drivers.
// Assumes plain copies of the carrier's signals, one sys_clk domain.
`timescale 1ns/1ps
module two_wire_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Lines and slave drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_scl_oe
);
  // ==========================================================
  // Slave conduct on the wire
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sda_hold_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave sda moved with scl high");
  stretch_low_a: assert property ($rose(dev_scl_oe) |-> !scl)
    else $error("stretch began with scl high");
  stretch_end_a: assert property ($rose(dev_scl_oe) |-> ##[1:300] !dev_scl_oe)
    else $error("scl held too long");
  stop_idle_a: assert property (scl && $rose(sda) |-> !dev_sda_oe && !dev_scl_oe)
    else $error("slave drives at stop");
  start_quiet_a: assert property (scl && $fell(sda) |-> !dev_sda_oe)
    else $error("slave drives at start");
  open_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("slave drives sda high");
  // Sync stages delay any reply past the falling edge
  sync_delay_a: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("sda driven too soon");
  ack_hold_a: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8])
    else $error("ack dropped in high phase");
  cover property (scl && $fell(sda));
  cover property ($rose(dev_scl_oe));
  cover property ($rose(dev_sda_oe));
endmodule // two_wire_chk

// *** dv/tb.sv ***
// Bench: master end writes and reads the gauge slave.
// Assumes the master's fixed line rate; frames are long.
`timescale 1ns/1ps
module tb;
  logic       sys_clk, reset_n, cmd_valid, cmd_read, done, ack_ok, rx_valid, rx_ready;
  logic       tx_valid, chg_fault, hw_dsg_on, pack_cutoff_cmd, uv_override, discharge_switch;
  logic       dsg_fault, tx_ready, frame_end, cmd_ready, pack_removed;
  logic       seen_rm = 1'b0, rm_off = 1'b0;
  logic [7:0] rd_data, rx_data, last_rx, cmd_wdata;
  logic [6:0] cmd_addr;
  int         err_count = 0, num_checks = 0, rx_cnt = 0, cyc = 0, fe_cnt = 0, tx_cnt = 0;
  two_wire_if bus ();
  gauge_two_wire_slave #(.REMOVE_CYCLES(64)) u_gauge_two_wire_slave (.sys_clk, .reset_n,
    .bus, .own_addr(7'h2a), .rx_data, .rx_valid, .rx_ready, .tx_data(8'h3c), .tx_valid,
    .tx_ready, .frame_end, .chg_fault, .dsg_fault, .hw_dsg_on, .pack_cutoff_cmd,
    .uv_override, .discharge_switch, .pack_removed);
  two_wire_master u_two_wire_master (.sys_clk, .reset_n, .bus, .cmd_valid, .cmd_read,
    .cmd_addr, .cmd_wdata, .cmd_ready, .done, .ack_ok, .rd_data);
  two_wire_chk u_two_wire_chk (.sys_clk, .reset_n, .scl(bus.scl), .sda(bus.sda),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .dev_scl_oe(bus.dev_scl_oe));
  // ==========================================================
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // User side: take bytes late, offer read data only once stalled
  always @(posedge sys_clk)
  begin
    rx_ready <= rx_valid && !rx_ready;
    tx_valid <= bus.dev_scl_oe;
    cyc <= cyc + 1;
    // Pulse counts and sticky removal flags, only once out of reset
    if (reset_n)
    begin
      fe_cnt  <= fe_cnt + int'(frame_end);
      tx_cnt  <= tx_cnt + int'(tx_ready);
      seen_rm <= seen_rm | pack_removed;
      rm_off  <= rm_off | (pack_removed & hw_dsg_on & !discharge_switch);
    end
    if (rx_valid && rx_ready)
    begin
      last_rx <= rx_data;
      rx_cnt  <= rx_cnt + 1;
    end
    if (cyc == 90000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame; waits for the done pulse
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd);
    @(posedge sys_clk);
    {cmd_valid, cmd_read, cmd_addr, cmd_wdata} <= {1'b1, rd, addr, wd};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    while (done !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    {reset_n, cmd_valid, cmd_read, cmd_addr, cmd_wdata} = '0;
    {chg_fault, dsg_fault, hw_dsg_on, pack_cutoff_cmd, uv_override} = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      {hw_dsg_on, pack_cutoff_cmd, uv_override} <= i[2:0];
      repeat (3) @(posedge sys_clk);
      #1;
      check({7'h0, discharge_switch}, {7'h0, i[2] & ~(i[1] | i[0])});
    end
    // Hardware on, no override cause: removal alone must cut discharge
    @(posedge sys_clk);
    {hw_dsg_on, pack_cutoff_cmd, uv_override} <= 3'h4;
    $display("test override done");
    xfer(1'b0, 7'h2a, 8'ha5);
    check({7'h0, ack_ok}, 8'h01);
    check(last_rx, 8'ha5);
    check(8'(rx_cnt), 8'h01);
    check(8'(fe_cnt), 8'h01);
    check({6'h0, seen_rm, pack_removed}, 8'h02);
    check({7'h0, rm_off}, 8'h01);
    $display("test write done");
    xfer(1'b1, 7'h2a, 8'h00);
    check(rd_data, 8'h3c);
    check(8'(tx_cnt), 8'h01);
    check({7'h0, cmd_ready}, 8'h01);
    $display("test read done");
    @(posedge sys_clk);
    chg_fault <= 1'b1;
    xfer(1'b0, 7'h2a, 8'h5a);
    check({7'h0, ack_ok}, 8'h00);
    check(8'(rx_cnt), 8'h01);
    @(posedge sys_clk);
    {chg_fault, dsg_fault} <= 2'h1;
    xfer(1'b0, 7'h2a, 8'h5a);
    check({7'h0, ack_ok}, 8'h00);
    check(8'(fe_cnt), 8'h02);
    $display("test fault done");
    @(posedge sys_clk);
    dsg_fault <= 1'b0;
    xfer(1'b0, 7'h15, 8'h77);
    check({7'h0, ack_ok}, 8'h00);
    check(8'(rx_cnt), 8'h01);
    check(8'(fe_cnt), 8'h03);
    $display("test mismatch done");
    report_and_stop();
  end
endmodule // tb
